// File: include/tcra_pkg.sv
// Constants, field layouts and carrier types for the primary trace
// control register, loaded over the test access port.
// Assumes a single clock domain shared with the trace control block.
//
// Operation
// - The block drives the core's trace control inputs, set and cleared, from the primary control register.
// - The register is written only by the test access port instruction whose code selects it, which the debugger must issue.
// - Bits 31 to 26 and bit 15 always read as zero, and the writer is expected to write zeros there.
// - Bits 25 to 24 are read only, follow the core's supported trace modes (00 PC only, 10 PC with address and data) and reset to 10.
// - Bit 23 is read only and reports the core's address and data trace bus width, zero for 16 bits and one for 32 bits.
// - Bit 19 selects full PC trace for all branches when one or only unpredictable branches when zero, and drives the all branch input.
// - Bit 18 asks the core to stall its pipeline rather than lose trace when its FIFO is full, and drives the overflow inhibit input.
// - Bit 17 enables trace in Debug mode together with the master enable, and when zero trace in Debug mode is always off.
// - Bit 16 with the master enable turns trace on outside Debug mode while the exception level or error level flag is one, and drives the exception input.
// - Bit 14 with the master enable turns trace on in kernel mode only while both level flags are zero, and drives the kernel input.
// - Bit 13 with the master enable turns trace on in user mode while both level flags are zero, and drives the user mode input.
// - Bits 12 to 5 hold a process identifier matched when the global bit is zero, drive the identifier input and are ignored by this core.
// - Bit 4 enables trace for all processes under the other conditions, drives the global input and is ignored by this core.
// - Bits 3 to 1 choose the traced content from PC only up to PC with both addresses and data, code 110 being unused.
// - Bit 0 is the master enable, resets to zero, keeps trace off unless the core's software override enables it, and drives trace on.

package tcra_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned TCRA_REG_W      = 32;
   localparam int unsigned TCRA_IR_W       = 5;
   localparam int unsigned TCRA_SYNC_LEN_W = 16;

   // ==========================================================
   // Instruction code and reset values
   localparam logic [TCRA_IR_W-1:0] TCRA_IR_CTRL_PRIMARY = 5'h10;
   localparam logic [5:0]           TCRA_RSVD_HI_VAL     = 6'h00;
   localparam logic                 TCRA_RSVD_MID_VAL    = 1'h0;
   localparam logic [1:0]           TCRA_MODES_RST       = 2'h2;
   localparam logic                 TCRA_BUS_W_RST       = 1'h0;
   localparam logic [2:0]           TCRA_SYNC_RST        = 3'h4;
   localparam logic                 TCRA_ON_RST          = 1'h0;
   localparam logic                 TCRA_UNDEF_RST       = 1'h0;
   localparam logic [7:0]           TCRA_PID_RST         = 8'h00;
   localparam logic [2:0]           TCRA_MODE_RST        = 3'h0;

   // ==========================================================
   // Sync period exponent bases
   localparam logic [4:0] TCRA_SYNC_ONCHIP_BASE  = 5'h02;
   localparam logic [4:0] TCRA_SYNC_OFFCHIP_BASE = 5'h07;

   // ==========================================================
   // Trace content codes
   localparam logic [2:0] TCRA_MODE_PC        = 3'h0;
   localparam logic [2:0] TCRA_MODE_LA        = 3'h1;
   localparam logic [2:0] TCRA_MODE_SA        = 3'h2;
   localparam logic [2:0] TCRA_MODE_LSA       = 3'h3;
   localparam logic [2:0] TCRA_MODE_LD        = 3'h4;
   localparam logic [2:0] TCRA_MODE_LA_LD     = 3'h5;
   localparam logic [2:0] TCRA_MODE_UNUSED    = 3'h6;
   localparam logic [2:0] TCRA_MODE_LSA_LSD   = 3'h7;

   // ==========================================================
   // Register image, most significant field first
   typedef struct packed {
      logic [5:0] rsvd_hi;
      logic [1:0] supported_trace_modes;
      logic       addr_data_bus_width;
      logic [2:0] sync_period_select;
      logic       all_branches_trace;
      logic       overflow_inhibit;
      logic       debug_trace;
      logic       exc_level_trace;
      logic       rsvd_mid;
      logic       kernel_trace;
      logic       user_trace;
      logic [7:0] process_id_match;
      logic       all_process;
      logic [2:0] trace_mode;
      logic       trace_on;
   } tcra_ctrl_reg_t;

   // Inputs of the core trace logic, driven by this block
   typedef struct packed {
      logic [2:0] sync_period_in;
      logic       all_branch_in;
      logic       overflow_inhibit_in;
      logic       debug_trace_in;
      logic       exc_level_trace_in;
      logic       kernel_trace_in;
      logic       user_trace_in;
      logic [7:0] process_id_in;
      logic       all_process_in;
      logic [2:0] trace_mode_in;
      logic       trace_on_in;
   } tcra_core_ctrl_t;

   // Core state seen by the enable evaluator
   typedef struct packed {
      logic debug_mode_flag;
      logic exception_level_flag;
      logic error_level_flag;
      logic user_mode_flag;
      logic sw_override_on;
   } tcra_core_status_t;

   // Test access port data register strobes
   typedef struct packed {
      logic [TCRA_IR_W-1:0] ir;
      logic                 capture_dr;
      logic                 shift_dr;
      logic                 update_dr;
      logic                 tdi;
   } tcra_tap_t;

   // Decoded trace content
   typedef struct packed {
      logic load_addr;
      logic store_addr;
      logic load_data;
      logic store_data;
      logic unused_code;
   } tcra_content_t;

   // Data register access phase
   typedef enum logic [2:0] {
      TCRA_ST_IDLE     = 3'b001,
      TCRA_ST_CAPTURED = 3'b010,
      TCRA_ST_SHIFTED  = 3'b100
   } tcra_state_t;

endpackage

// File: hw/tcra_shift.sv
// Test access port data shift register for one register image.
// Assumes capture, shift and tdi are synchronous; capture is a one-cycle strobe, shift may be held.
`timescale 1ns/100ps
`default_nettype none

module tcra_shift #(
   parameter int unsigned WIDTH = tcra_pkg::TCRA_REG_W
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             capture_in,
   input  wire logic             shift_in,
   input  wire logic             tdi_in,
   input  wire logic [WIDTH-1:0] capture_data_in,
   output logic      [WIDTH-1:0] data_out,
   output logic                  tdo_out
);

   logic [WIDTH-1:0] shift_q;
   logic [WIDTH-1:0] shift_d;

   // ==========================================================
   // Next value
   always_comb
   begin
      shift_d = shift_q;
      if (capture_in)
      begin
         shift_d = capture_data_in;
      end
      else if (shift_in)
      begin
         // Least significant bit leaves first
         shift_d = {tdi_in, shift_q[WIDTH-1:1]};
      end
   end

   // ==========================================================
   // Storage
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         shift_q <= '0;
      end
      else
      begin
         shift_q <= shift_d;
      end
   end

   assign data_out = shift_q;
   assign tdo_out  = shift_q[0];

endmodule // tcra_shift

`default_nettype wire

// File: hw/tcra_top.sv
// Primary trace control register with its core-facing control outputs.
// Assumes test access port strobes and core flags are synchronous to
// clk_in, and that the instruction register value is stable around them.
`timescale 1ns/100ps
`default_nettype none

module tcra_top (
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   input  wire tcra_pkg::tcra_tap_t          tap_in,
   input  wire logic [1:0]                   core_supported_modes_in,
   input  wire logic                         addr_data_bus_width_in,
   input  wire tcra_pkg::tcra_core_status_t  core_status_in,
   input  wire logic                         offchip_trace_in,
   output logic                              tap_tdo_out,
   output tcra_pkg::tcra_core_ctrl_t         core_ctrl_out,
   output tcra_pkg::tcra_content_t           trace_content_out,
   output logic                              trace_enabled_out,
   output logic [tcra_pkg::TCRA_SYNC_LEN_W-1:0] sync_period_len_out
);

   // ==========================================================
   // Decoding helpers

   // Period of sync records for a code and a destination
   function automatic logic [tcra_pkg::TCRA_SYNC_LEN_W-1:0] sync_len_f(
      input logic [2:0] code,
      input logic       offchip
   );
      logic [4:0] expo;
      expo = (offchip ? tcra_pkg::TCRA_SYNC_OFFCHIP_BASE
                      : tcra_pkg::TCRA_SYNC_ONCHIP_BASE) + {2'h0, code};
      sync_len_f = {{(tcra_pkg::TCRA_SYNC_LEN_W-1){1'b0}}, 1'b1} << expo;
   endfunction

   // Traced content for a mode code
   function automatic tcra_pkg::tcra_content_t content_f(
      input logic [2:0] code
   );
      tcra_pkg::tcra_content_t c;
      c = '0;
      unique case (code)
         tcra_pkg::TCRA_MODE_PC:      c = '0;
         tcra_pkg::TCRA_MODE_LA:      c.load_addr = 1'b1;
         tcra_pkg::TCRA_MODE_SA:      c.store_addr = 1'b1;
         tcra_pkg::TCRA_MODE_LSA:
         begin
            c.load_addr  = 1'b1;
            c.store_addr = 1'b1;
         end
         tcra_pkg::TCRA_MODE_LD:      c.load_data = 1'b1;
         tcra_pkg::TCRA_MODE_LA_LD:
         begin
            c.load_addr = 1'b1;
            c.load_data = 1'b1;
         end
         tcra_pkg::TCRA_MODE_UNUSED:  c.unused_code = 1'b1;
         tcra_pkg::TCRA_MODE_LSA_LSD:
         begin
            c.load_addr  = 1'b1;
            c.store_addr = 1'b1;
            c.load_data  = 1'b1;
            c.store_data = 1'b1;
         end
      endcase
      content_f = c;
   endfunction

   // ==========================================================
   // Access phase tracking
   tcra_pkg::tcra_state_t st_q;
   tcra_pkg::tcra_state_t st_d;
   logic                  sel;
   logic                  commit;

   assign sel = (tap_in.ir == tcra_pkg::TCRA_IR_CTRL_PRIMARY);

   always_comb
   begin
      st_d   = st_q;
      commit = 1'b0;
      unique case (st_q)
         tcra_pkg::TCRA_ST_IDLE:
         begin
            if (sel && tap_in.capture_dr)
            begin
               st_d = tcra_pkg::TCRA_ST_CAPTURED;
            end
         end
         tcra_pkg::TCRA_ST_CAPTURED,
         tcra_pkg::TCRA_ST_SHIFTED:
         begin
            if (!sel)
            begin
               // Instruction changed mid-scan: drop it
               st_d = tcra_pkg::TCRA_ST_IDLE;
            end
            else if (tap_in.update_dr)
            begin
               commit = 1'b1;
               st_d   = tcra_pkg::TCRA_ST_IDLE;
            end
            else if (tap_in.shift_dr)
            begin
               st_d = tcra_pkg::TCRA_ST_SHIFTED;
            end
         end
         default:
         begin
            st_d = tcra_pkg::TCRA_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_q <= tcra_pkg::TCRA_ST_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Shift path
   tcra_pkg::tcra_ctrl_reg_t ctrl_q;
   tcra_pkg::tcra_ctrl_reg_t ctrl_d;
   tcra_pkg::tcra_ctrl_reg_t readback;
   logic [tcra_pkg::TCRA_REG_W-1:0] shifted;

   tcra_shift #(
      .WIDTH (tcra_pkg::TCRA_REG_W)
   ) u_shift (
      .clk_in          (clk_in),
      .rst_in          (rst_in),
      .capture_in      (sel && tap_in.capture_dr),
      .shift_in        (sel && tap_in.shift_dr),
      .tdi_in          (tap_in.tdi),
      .capture_data_in (readback),
      .data_out        (shifted),
      .tdo_out         (tap_tdo_out)
   );

   always_comb
   begin
      readback         = ctrl_q;
      readback.rsvd_hi  = tcra_pkg::TCRA_RSVD_HI_VAL;
      readback.rsvd_mid = tcra_pkg::TCRA_RSVD_MID_VAL;
   end

   // ==========================================================
   // Register next value
   always_comb
   begin
      tcra_pkg::tcra_ctrl_reg_t w;
      w      = shifted;
      ctrl_d = ctrl_q;
      ctrl_d.supported_trace_modes = core_supported_modes_in;
      ctrl_d.addr_data_bus_width   = addr_data_bus_width_in;
      if (commit)
      begin
         ctrl_d.sync_period_select = w.sync_period_select;
         ctrl_d.all_branches_trace = w.all_branches_trace;
         ctrl_d.overflow_inhibit   = w.overflow_inhibit;
         ctrl_d.debug_trace        = w.debug_trace;
         ctrl_d.exc_level_trace    = w.exc_level_trace;
         ctrl_d.kernel_trace       = w.kernel_trace;
         ctrl_d.user_trace         = w.user_trace;
         ctrl_d.process_id_match   = w.process_id_match;
         ctrl_d.all_process        = w.all_process;
         ctrl_d.trace_mode         = w.trace_mode;
         ctrl_d.trace_on           = w.trace_on;
      end
      ctrl_d.rsvd_hi  = tcra_pkg::TCRA_RSVD_HI_VAL;
      ctrl_d.rsvd_mid = tcra_pkg::TCRA_RSVD_MID_VAL;
   end

   // ==========================================================
   // Enable evaluation, mirrors what the core decides
   logic trace_en_d;
   logic in_exc;

   always_comb
   begin
      in_exc     = core_status_in.exception_level_flag
                   || core_status_in.error_level_flag;
      trace_en_d = 1'b0;
      if (core_status_in.debug_mode_flag)
      begin
         trace_en_d = ctrl_q.debug_trace;
      end
      else if (in_exc)
      begin
         trace_en_d = ctrl_q.exc_level_trace;
      end
      else if (core_status_in.user_mode_flag)
      begin
         trace_en_d = ctrl_q.user_trace;
      end
      else
      begin
         trace_en_d = ctrl_q.kernel_trace;
      end
      trace_en_d = trace_en_d
                   && (ctrl_q.trace_on || core_status_in.sw_override_on);
      // no process identifier here, match ignored
   end

   // ==========================================================
   // Storage of register and derived outputs
   tcra_pkg::tcra_core_ctrl_t core_d;

   always_comb
   begin
      core_d.sync_period_in      = ctrl_d.sync_period_select;
      core_d.all_branch_in       = ctrl_d.all_branches_trace;
      core_d.overflow_inhibit_in = ctrl_d.overflow_inhibit;
      core_d.debug_trace_in      = ctrl_d.debug_trace;
      core_d.exc_level_trace_in  = ctrl_d.exc_level_trace;
      core_d.kernel_trace_in     = ctrl_d.kernel_trace;
      core_d.user_trace_in       = ctrl_d.user_trace;
      core_d.process_id_in       = ctrl_d.process_id_match;
      core_d.all_process_in      = ctrl_d.all_process;
      core_d.trace_mode_in       = ctrl_d.trace_mode;
      core_d.trace_on_in         = ctrl_d.trace_on;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ctrl_q.rsvd_hi               <= tcra_pkg::TCRA_RSVD_HI_VAL;
         ctrl_q.supported_trace_modes <= tcra_pkg::TCRA_MODES_RST;
         ctrl_q.addr_data_bus_width   <= tcra_pkg::TCRA_BUS_W_RST;
         ctrl_q.sync_period_select    <= tcra_pkg::TCRA_SYNC_RST;
         // Undefined fields pinned for repeatable starts
         ctrl_q.all_branches_trace    <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.overflow_inhibit      <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.debug_trace           <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.exc_level_trace       <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.rsvd_mid              <= tcra_pkg::TCRA_RSVD_MID_VAL;
         ctrl_q.kernel_trace          <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.user_trace            <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.process_id_match      <= tcra_pkg::TCRA_PID_RST;
         ctrl_q.all_process           <= tcra_pkg::TCRA_UNDEF_RST;
         ctrl_q.trace_mode            <= tcra_pkg::TCRA_MODE_RST;
         ctrl_q.trace_on              <= tcra_pkg::TCRA_ON_RST;
         core_ctrl_out                <= '0;
         core_ctrl_out.sync_period_in <= tcra_pkg::TCRA_SYNC_RST;
         trace_content_out            <= '0;
         trace_enabled_out            <= 1'b0;
         sync_period_len_out          <= '0;
      end
      else
      begin
         ctrl_q              <= ctrl_d;
         core_ctrl_out       <= core_d;
         trace_content_out   <= content_f(ctrl_q.trace_mode);
         trace_enabled_out   <= trace_en_d;
         sync_period_len_out <= sync_len_f(ctrl_q.sync_period_select,
                                           offchip_trace_in);
      end
   end

endmodule // tcra_top

`default_nettype wire

// File: bench/tcra_chk.sv
// Port-level checker for the primary trace control register.
// Assumes binding to tcra_top; sees only its ports, one clock domain.
`timescale 1ns/100ps
`default_nettype none

module tcra_chk (
   input wire logic                        clk_in,
   input wire logic                        rst_in,
   input wire tcra_pkg::tcra_tap_t         tap_in,
   input wire logic [1:0]                  core_supported_modes_in,
   input wire logic                        addr_data_bus_width_in,
   input wire tcra_pkg::tcra_core_status_t core_status_in,
   input wire logic                        offchip_trace_in,
   input wire logic                        tap_tdo_out,
   input wire tcra_pkg::tcra_core_ctrl_t   core_ctrl_out,
   input wire tcra_pkg::tcra_content_t     trace_content_out,
   input wire logic                        trace_enabled_out,
   input wire logic [tcra_pkg::TCRA_SYNC_LEN_W-1:0] sync_period_len_out
);
   // ==========================================================
   // Reference decisions
   function automatic logic en_fn(tcra_pkg::tcra_core_ctrl_t c,
                                  tcra_pkg::tcra_core_status_t s);
      logic m;
      if (s.debug_mode_flag)
         m = c.debug_trace_in;
      else if (s.exception_level_flag || s.error_level_flag)
         m = c.exc_level_trace_in;
      else if (s.user_mode_flag)
         m = c.user_trace_in;
      else
         m = c.kernel_trace_in;
      return m && (c.trace_on_in || s.sw_override_on);
   endfunction

   function automatic tcra_pkg::tcra_content_t ct_fn(logic [2:0] m);
      return {m[0], m == 3'h2 || m == 3'h3 || m == 3'h7,
              m == 3'h4 || m == 3'h5 || m == 3'h7, m == 3'h7, m == 3'h6};
   endfunction

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // ==========================================================
   // Assertions
   // reset image
   a_ctrl_reset_val: assert property (
      $fell(rst_in) |-> core_ctrl_out == {3'h4, 19'h0} && !trace_enabled_out)
      else $error("core controls wrong after reset");
   // only an update moves the controls
   a_ctrl_hold_quiet: assert property (
      !$past(rst_in) && !$past(tap_in.update_dr) &&
      !$past(tap_in.update_dr, 2) |-> $stable(core_ctrl_out))
      else $error("core controls moved without an update");
   a_ir_select_only: assert property (
      tap_in.update_dr && tap_in.ir != tcra_pkg::TCRA_IR_CTRL_PRIMARY
      |=> $stable(core_ctrl_out) ##1 $stable(core_ctrl_out))
      else $error("update under another instruction took effect");
   a_capture_tdo_bit: assert property (
      tap_in.capture_dr && tap_in.ir == tcra_pkg::TCRA_IR_CTRL_PRIMARY
      |=> tap_tdo_out == $past(core_ctrl_out.trace_on_in))
      else $error("first scanned bit is not the enable bit");
   a_sync_len_pow: assert property (
      !$past(rst_in) |-> sync_period_len_out == (16'h1 <<
      ($past(core_ctrl_out.sync_period_in) +
      ($past(offchip_trace_in) ? 5'h07 : 5'h02))))
      else $error("sync period length wrong");
   a_content_map_ok: assert property (
      !$past(rst_in) |->
      trace_content_out == $past(ct_fn(core_ctrl_out.trace_mode_in)))
      else $error("trace content decode wrong");
   a_enable_mirror_ok: assert property (
      !$past(rst_in) |->
      trace_enabled_out == $past(en_fn(core_ctrl_out, core_status_in)))
      else $error("trace enable decision wrong");
   a_debug_block_off: assert property (
      $past(core_status_in.debug_mode_flag) &&
      !$past(core_ctrl_out.debug_trace_in) |-> !trace_enabled_out)
      else $error("trace on in debug mode with debug bit clear");
   a_master_gate_off: assert property (
      !$past(core_ctrl_out.trace_on_in) &&
      !$past(core_status_in.sw_override_on) |-> !trace_enabled_out)
      else $error("trace on with master enable clear");
endmodule // tcra_chk

bind tcra_top tcra_chk tcra_chk_i (.clk_in, .rst_in, .tap_in,
   .core_supported_modes_in, .addr_data_bus_width_in, .core_status_in,
   .offchip_trace_in, .tap_tdo_out, .core_ctrl_out, .trace_content_out,
   .trace_enabled_out, .sync_period_len_out);
`default_nettype wire

// File: bench/tcra_core_model.sv
// Behavioural model of the core trace logic beside the register.
// Assumes commands from the bench change off the rising edge.
`timescale 1ns/100ps
`default_nettype none

module tcra_core_model (
   input  wire logic                        clk_in,
   input  wire logic                        full_cap_in,
   input  wire logic                        wide_bus_in,
   input  wire tcra_pkg::tcra_core_status_t status_cmd_in,
   input  wire tcra_pkg::tcra_core_ctrl_t   ctrl_in,
   output logic [1:0]                       supported_modes_out,
   output logic                             bus_width_out,
   output tcra_pkg::tcra_core_status_t      status_out,
   output logic                             trace_active_out
);
   // ==========================================================
   // Capability
   // modes code
   assign supported_modes_out = full_cap_in ? 2'h2 : 2'h0;
   assign bus_width_out = wide_bus_in;

   // Status moves on the clock, as a real core's would
   always_ff @(posedge clk_in)
      status_out <= status_cmd_in;

   // ==========================================================
   // Core view of the enable inputs
   // decision
   always_comb
   begin
      if (status_out.debug_mode_flag)
         trace_active_out = ctrl_in.debug_trace_in;
      else if (status_out.exception_level_flag || status_out.error_level_flag)
         trace_active_out = ctrl_in.exc_level_trace_in;
      else if (status_out.user_mode_flag)
         trace_active_out = ctrl_in.user_trace_in;
      else
         trace_active_out = ctrl_in.kernel_trace_in;
      trace_active_out = trace_active_out &&
                         (ctrl_in.trace_on_in || status_out.sw_override_on);
   end
endmodule // tcra_core_model
`default_nettype wire

// File: bench/tcra_top_test.sv
// Self-checking bench for the primary trace control register.
// Assumes tcra_top with the core model on its core-facing ports.
`timescale 1ns/100ps
`default_nettype none

module tcra_top_test;
   localparam logic [4:0] IR = tcra_pkg::TCRA_IR_CTRL_PRIMARY;
   logic                        clk, rst, tdo, off, full, wide, act, en_out;
   logic [1:0]                  modes;
   logic                        bw;
   logic [15:0]                 slen;
   logic [31:0]                 rd, w;
   tcra_pkg::tcra_tap_t         tap;
   tcra_pkg::tcra_core_status_t scmd, stat;
   tcra_pkg::tcra_core_ctrl_t   ctrl;
   tcra_pkg::tcra_content_t     cont;
   int                          n_errors, num_checks;
   logic [4:0] ct_tbl [0:7] = '{5'h00, 5'h10, 5'h08, 5'h18,
                                5'h04, 5'h14, 5'h01, 5'h1e};

   tcra_top tcra_top_i (.clk_in(clk), .rst_in(rst), .tap_in(tap),
      .core_supported_modes_in(modes), .addr_data_bus_width_in(bw),
      .core_status_in(stat), .offchip_trace_in(off), .tap_tdo_out(tdo),
      .core_ctrl_out(ctrl), .trace_content_out(cont),
      .trace_enabled_out(en_out), .sync_period_len_out(slen));
   tcra_core_model tcra_core_model_i (.clk_in(clk), .full_cap_in(full),
      .wide_bus_in(wide), .status_cmd_in(scmd), .ctrl_in(ctrl),
      .supported_modes_out(modes), .bus_width_out(bw), .status_out(stat),
      .trace_active_out(act));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Capture, 32 shifts LSB first, update; returns the old image
   task automatic scan(input logic [4:0] ir, input logic [31:0] wr,
                       output logic [31:0] r);
      @(negedge clk);
      tap.ir = ir;
      tap.capture_dr = 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         @(negedge clk);
         r[i] = tdo;
         tap.capture_dr = 1'b0;
         tap.shift_dr = 1'b1;
         tap.tdi = wr[i];
      end
      @(negedge clk);
      tap.shift_dr = 1'b0;
      tap.update_dr = 1'b1;
      @(negedge clk);
      tap.update_dr = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      #(8 * 20000);
      n_errors++;
      tally_and_finish;
   end

   // ==========================================================
   // Tests
   initial
   begin
      rst = 1'b1;
      tap = '0;
      scmd = '0;
      off = 1'b0;
      full = 1'b1;
      wide = 1'b0;
      n_errors = 0;
      num_checks = 0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk({10'h0, ctrl}, {10'h0, 3'h4, 19'h0});
      scan(IR, 32'h0, rd);
      chk(rd, 32'h0240_0000);
      $display("test reset done");
      full = 1'b0;
      wide = 1'b1;
      scan(IR, 32'hffff_ffff, rd);
      chk({10'h0, ctrl}, 32'h003f_ffff);
      scan(IR, 32'h0, rd);
      chk(rd, {6'h0, 2'h0, 1'h1, 7'h7f, 1'h0, 15'h7fff});
      $display("test fields done");
      for (int i = 0; i < 8; i++)
      begin
         off = i[0];
         w = {9'h0, i[2:0], 16'h0, i[2:0], 1'b1};
         scan(IR, w, rd);
         chk({10'h0, ctrl}, {10'h0, w[22:16], w[14:0]});
         chk({16'h0, slen}, 32'h1 << (i + (i[0] ? 7 : 2)));
         chk({27'h0, cont}, {27'h0, ct_tbl[i]});
      end
      $display("test codes done");
      foreach (ct_tbl[k])
      begin
         w = k == 0 ? 32'h0002_4001 : k == 1 ? 32'h0001_2001 : 32'h0003_6000;
         if (k < 3)
         begin
            scan(IR, w, rd);
            for (int s = 0; s < 32; s++)
            begin
               scmd = s[4:0];
               repeat (3) @(negedge clk);
               chk({31'h0, en_out}, {31'h0, act});
            end
         end
      end
      $display("test enables done");
      scan(5'h11, 32'h5555_5555, rd);
      // Scan dropped by an instruction change must not commit
      @(negedge clk);
      tap.ir = IR;
      tap.capture_dr = 1'b1;
      @(negedge clk);
      tap.capture_dr = 1'b0;
      tap.shift_dr = 1'b1;
      @(negedge clk);
      tap.shift_dr = 1'b0;
      tap.ir = 5'h11;
      @(negedge clk);
      tap.ir = IR;
      tap.update_dr = 1'b1;
      @(negedge clk);
      tap.update_dr = 1'b0;
      repeat (3) @(negedge clk);
      chk({10'h0, ctrl}, 32'h0001_e000);
      $display("test refusal done");
      tally_and_finish;
   end
endmodule // tcra_top_test
`default_nettype wire
